// [pkg/ufci_pkg.sv]
// constants shared by the uart fifo control and interrupt identification block
package ufci_pkg;
	//----------------------------------------
	// register byte addresses
	//----------------------------------------
	localparam logic [7:0] ADDR_FIFO_SETUP = 8'h00;
	localparam logic [7:0] ADDR_INT_ID     = 8'h04;
	localparam logic [7:0] ADDR_ENH        = 8'h08;
	localparam logic [7:0] ADDR_TX_DATA    = 8'h0C;
	localparam logic [7:0] ADDR_RX_DATA    = 8'h10;
	localparam logic [7:0] ADDR_LEVELS     = 8'h14;

	//----------------------------------------
	// field positions
	//----------------------------------------
	localparam int FS_ENABLE   = 0;
	localparam int FS_RX_RESET = 1;
	localparam int FS_TX_RESET = 2;
	localparam int FS_DMA_MODE = 3;
	localparam int FS_TX_TRIG  = 4;
	localparam int FS_RX_TRIG  = 6;
	localparam int ENH_ENABLE  = 4;
	localparam int LVL_RX_POS  = 8;

	//----------------------------------------
	// reset values
	//----------------------------------------
	localparam logic [7:0] FIFO_SETUP_RST = 8'h00;
	localparam logic [7:0] ENH_RST        = 8'h00;
	localparam logic       TX_READY_RST   = 1'h0;
	localparam logic       RX_READY_RST   = 1'h1;

	//----------------------------------------
	// fifo sizes and trigger levels
	//----------------------------------------
	localparam int         FIFO_DEPTH = 32;
	localparam logic [5:0] CAP_HOLD   = 6'h01;
	localparam logic [5:0] RX_TRIG_0  = 6'h08;
	localparam logic [5:0] RX_TRIG_1  = 6'h10;
	localparam logic [5:0] RX_TRIG_2  = 6'h18;
	localparam logic [5:0] RX_TRIG_3  = 6'h1C;
	localparam logic [5:0] TX_TRIG_0  = 6'h10;
	localparam logic [5:0] TX_TRIG_1  = 6'h08;
	localparam logic [5:0] TX_TRIG_2  = 6'h18;
	localparam logic [5:0] TX_TRIG_3  = 6'h1E;

	//----------------------------------------
	// identification codes, bits five to zero
	//----------------------------------------
	localparam logic [5:0] ID_LINE  = 6'h06;
	localparam logic [5:0] ID_RXDAT = 6'h04;
	localparam logic [5:0] ID_RXTMO = 6'h0C;
	localparam logic [5:0] ID_THRE  = 6'h02;
	localparam logic [5:0] ID_MODEM = 6'h00;
	localparam logic [5:0] ID_XOFF  = 6'h10;
	localparam logic [5:0] ID_FLOW  = 6'h20;
	localparam logic [5:0] ID_NONE  = 6'h01;

	//----------------------------------------
	// bus responses
	//----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/ufci_fifo.sv]
// character fifo with fill counter and flush
`timescale 1ns/1ps
`default_nettype none
module ufci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = ufci_pkg::FIFO_DEPTH
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       flush,
	input  wire logic                       push,
	input  wire logic [WIDTH-1:0]           wdata,
	input  wire logic                       pop,
	output logic      [WIDTH-1:0]           rdata,
	output logic      [$clog2(DEPTH):0]     count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push_ok;
	logic             pop_ok;

	// full and empty guards
	assign push_ok = push && (count != (AW+1)'(DEPTH));
	assign pop_ok  = pop && (count != '0);
	assign rdata   = mem[rd_ptr];

	// storage, no reset needed
	always_ff @(posedge aclk) begin
		if (push_ok) begin
			mem[wr_ptr] <= wdata;
		end
	end

	// pointers and counter, flush empties everything
	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop_ok) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push_ok && !pop_ok) begin
				count <= count + 1'b1;
			end else if (pop_ok && !push_ok) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/ufci_top.sv]
// uart channel fifo control, dma ready pins and interrupt identification
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - block dma mode: tx ready high when fifo full, low at trigger level
// - block dma mode: rx ready low at trigger or time-out, high when empty
// - tx fifo reset empties tx fifo, spares shifter, then self-clears
// - rx fifo reset empties rx fifo, spares shifter, then self-clears
// - enable bit turns both fifos on or off, off after reset
// - other setup fields are written only when enable bit written one
// - rx trigger codes 00..11 give 8, 16, 24, 28 bytes
// - tx trigger codes 00..11 give 16, 8, 24, 30 bytes
// - seven priority levels, identification shows highest pending code
// - lower level shows only after higher one is serviced and re-read
// - codes 06 line status, 04 rx data, 0C rx time-out
// - codes 02 transmit empty, 00 modem status change
// - codes 10 xoff or special character, 20 cts/rts change
// - top two identification bits mirror fifo enable, zero after reset
// - codes 10 and 20 appear only with enhanced feature bit set
// - xoff flag stays set until matching xon arrives
// - bit zero reads zero when pending, one when idle and after reset
// - single dma mode: tx ready low when empty, high after first char
// - single dma mode: rx ready low with any char, high when none
// - transmit empty cleared by identification read or new character
module ufci_top #(
	parameter int FIFO_DEPTH = ufci_pkg::FIFO_DEPTH
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char,
	output logic [7:0]       tx_char,
	output logic             tx_char_valid,
	input  wire logic        tx_shift_ready,
	input  wire logic        line_status_err,
	input  wire logic        rx_timeout,
	input  wire logic        modem_change,
	input  wire logic        xoff_detected,
	input  wire logic        xon_detected,
	input  wire logic        cts_rts_change,
	output logic             tx_dma_ready_n,
	output logic             rx_dma_ready_n
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	//----------------------------------------
	// declarations
	//----------------------------------------
	logic [7:0]    aw_addr;
	logic          aw_held;
	logic [7:0]    w_byte;
	logic          w_lane0;
	logic          w_held;
	logic          do_write;
	logic          do_read;
	logic          wr_hit;
	logic [31:0]   next_rdata;
	logic [1:0]    next_rresp;
	logic          fifo_en;
	logic          dma_mode;
	logic [1:0]    tx_trig_sel;
	logic [1:0]    rx_trig_sel;
	logic          tx_flush;
	logic          rx_flush;
	logic [7:0]    enh_reg;
	logic [CW-1:0] cap;
	logic [CW-1:0] tx_count;
	logic [CW-1:0] rx_count;
	logic [CW-1:0] tx_trig;
	logic [CW-1:0] rx_trig;
	logic [7:0]    tx_head;
	logic [7:0]    rx_head;
	logic          tx_push;
	logic          tx_pop;
	logic          rx_push;
	logic          rx_pop;
	logic          wr_setup;
	logic          isr_read;
	logic          tx_was_busy;
	logic          thr_pend;
	logic          xoff_flag;
	logic          flow_flag;
	logic          enh_on;
	logic          rx_data_int;
	logic          rx_tmo_int;
	logic [5:0]    isr_code;

	//----------------------------------------
	// axi4-lite write channel
	//----------------------------------------
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_hit   = (aw_addr == ufci_pkg::ADDR_FIFO_SETUP) || (aw_addr == ufci_pkg::ADDR_ENH)
		|| (aw_addr == ufci_pkg::ADDR_TX_DATA);

	// address and data taken independently, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= awaddr;
		end else if (do_write) begin
			awready <= 1'b1;
			aw_held <= 1'b0;
		end
	end

	// write data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready  <= 1'b1;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			w_held  <= 1'b1;
			w_byte  <= wdata[7:0];
			w_lane0 <= wstrb[0];
		end else if (do_write) begin
			wready <= 1'b1;
			w_held <= 1'b0;
		end
	end

	// write response, error for unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= ufci_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? ufci_pkg::RESP_OKAY : ufci_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	//----------------------------------------
	// fifo setup register
	//----------------------------------------
	assign wr_setup = do_write && w_lane0 && (aw_addr == ufci_pkg::ADDR_FIFO_SETUP);

	// fields load only alongside a one in the enable bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_en     <= ufci_pkg::FIFO_SETUP_RST[ufci_pkg::FS_ENABLE];
			dma_mode    <= ufci_pkg::FIFO_SETUP_RST[ufci_pkg::FS_DMA_MODE];
			tx_trig_sel <= ufci_pkg::FIFO_SETUP_RST[ufci_pkg::FS_TX_TRIG +: 2];
			rx_trig_sel <= ufci_pkg::FIFO_SETUP_RST[ufci_pkg::FS_RX_TRIG +: 2];
		end else if (wr_setup) begin
			fifo_en <= w_byte[ufci_pkg::FS_ENABLE];
			if (w_byte[ufci_pkg::FS_ENABLE]) begin
				dma_mode    <= w_byte[ufci_pkg::FS_DMA_MODE];
				tx_trig_sel <= w_byte[ufci_pkg::FS_TX_TRIG +: 2];
				rx_trig_sel <= w_byte[ufci_pkg::FS_RX_TRIG +: 2];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_flush <= 1'b0;
			rx_flush <= 1'b0;
		end else begin
			tx_flush <= wr_setup && w_byte[ufci_pkg::FS_ENABLE] && w_byte[ufci_pkg::FS_TX_RESET];
			rx_flush <= wr_setup && w_byte[ufci_pkg::FS_ENABLE] && w_byte[ufci_pkg::FS_RX_RESET];
		end
	end

	// enhanced feature register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enh_reg <= ufci_pkg::ENH_RST;
		end else if (do_write && w_lane0 && (aw_addr == ufci_pkg::ADDR_ENH)) begin
			enh_reg <= w_byte;
		end
	end
	assign enh_on = enh_reg[ufci_pkg::ENH_ENABLE];

	//----------------------------------------
	// trigger levels and fifos
	//----------------------------------------
	// rx and tx trigger tables
	always_comb begin
		unique case (rx_trig_sel)
			2'h0: rx_trig = CW'(ufci_pkg::RX_TRIG_0);
			2'h1: rx_trig = CW'(ufci_pkg::RX_TRIG_1);
			2'h2: rx_trig = CW'(ufci_pkg::RX_TRIG_2);
			2'h3: rx_trig = CW'(ufci_pkg::RX_TRIG_3);
		endcase
		unique case (tx_trig_sel)
			2'h0: tx_trig = CW'(ufci_pkg::TX_TRIG_0);
			2'h1: tx_trig = CW'(ufci_pkg::TX_TRIG_1);
			2'h2: tx_trig = CW'(ufci_pkg::TX_TRIG_2);
			2'h3: tx_trig = CW'(ufci_pkg::TX_TRIG_3);
		endcase
	end

	// disabled fifos behave as a single holding register
	assign cap      = fifo_en ? CW'(FIFO_DEPTH) : CW'(ufci_pkg::CAP_HOLD);
	assign isr_read = do_read && (araddr == ufci_pkg::ADDR_INT_ID);
	assign tx_push  = do_write && w_lane0 && (aw_addr == ufci_pkg::ADDR_TX_DATA) && (tx_count < cap);
	assign tx_pop   = (tx_count != '0) && (!tx_char_valid || tx_shift_ready) && !tx_flush;
	assign rx_push  = rx_char_valid && (rx_count < cap);
	assign rx_pop   = do_read && (araddr == ufci_pkg::ADDR_RX_DATA);

	ufci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.flush   (tx_flush),
		.push    (tx_push),
		.wdata   (w_byte),
		.pop     (tx_pop),
		.rdata   (tx_head),
		.count   (tx_count)
	);

	ufci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.flush   (rx_flush),
		.push    (rx_push),
		.wdata   (rx_char),
		.pop     (rx_pop),
		.rdata   (rx_head),
		.count   (rx_count)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_char_valid <= 1'b0;
			tx_char       <= 8'h00;
		end else if (tx_pop) begin
			tx_char_valid <= 1'b1;
			tx_char       <= tx_head;
		end else if (tx_shift_ready) begin
			tx_char_valid <= 1'b0;
		end
	end

	//----------------------------------------
	// dma ready pins
	//----------------------------------------
	// tx ready, block mode and single mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_dma_ready_n <= ufci_pkg::TX_READY_RST;
		end else if (fifo_en && dma_mode) begin
			if (tx_count == cap) begin
				tx_dma_ready_n <= 1'b1;
			end else if (tx_count <= tx_trig) begin
				tx_dma_ready_n <= 1'b0;
			end
		end else begin
			tx_dma_ready_n <= (tx_count != '0);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_dma_ready_n <= ufci_pkg::RX_READY_RST;
		end else if (fifo_en && dma_mode) begin
			if (rx_count == '0) begin
				rx_dma_ready_n <= 1'b1;
			end else if ((rx_count >= rx_trig) || rx_timeout) begin
				rx_dma_ready_n <= 1'b0;
			end
		end else begin
			rx_dma_ready_n <= (rx_count == '0);
		end
	end

	//----------------------------------------
	// interrupt sources
	//----------------------------------------
	assign rx_data_int = fifo_en ? (rx_count >= rx_trig) : (rx_count != '0);
	assign rx_tmo_int  = rx_timeout && (rx_count != '0);

	// transmit empty, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_was_busy <= 1'b0;
			thr_pend    <= 1'b0;
		end else begin
			tx_was_busy <= (tx_count != '0);
			if (tx_was_busy && (tx_count == '0)) begin
				thr_pend <= 1'b1;
			end else if (isr_read || tx_push) begin
				thr_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xoff_flag <= 1'b0;
		end else if (xoff_detected) begin
			xoff_flag <= 1'b1;
		end else if (xon_detected) begin
			xoff_flag <= 1'b0;
		end
	end

	// flow change sticky until identification read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flow_flag <= 1'b0;
		end else if (cts_rts_change) begin
			flow_flag <= 1'b1;
		end else if (isr_read) begin
			flow_flag <= 1'b0;
		end
	end

	always_comb begin
		if (line_status_err) begin
			isr_code = ufci_pkg::ID_LINE;
		end else if (rx_data_int) begin
			isr_code = ufci_pkg::ID_RXDAT;
		end else if (rx_tmo_int) begin
			isr_code = ufci_pkg::ID_RXTMO;
		end else if (thr_pend) begin
			isr_code = ufci_pkg::ID_THRE;
		end else if (modem_change) begin
			isr_code = ufci_pkg::ID_MODEM;
		end else if (enh_on && xoff_flag) begin
			isr_code = ufci_pkg::ID_XOFF;
		end else if (enh_on && flow_flag) begin
			isr_code = ufci_pkg::ID_FLOW;
		end else begin
			isr_code = ufci_pkg::ID_NONE;
		end
	end

	//----------------------------------------
	// axi4-lite read channel
	//----------------------------------------
	assign do_read = arvalid && arready;

	// read mux, setup reset bits read back zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = ufci_pkg::RESP_OKAY;
		unique case (araddr)
			ufci_pkg::ADDR_FIFO_SETUP: next_rdata[7:0] = {rx_trig_sel, tx_trig_sel, dma_mode, 2'h0, fifo_en};
			ufci_pkg::ADDR_INT_ID:     next_rdata[7:0] = {fifo_en, fifo_en, isr_code};
			ufci_pkg::ADDR_ENH:        next_rdata[7:0] = enh_reg;
			ufci_pkg::ADDR_RX_DATA:    next_rdata[7:0] = rx_head;
			ufci_pkg::ADDR_LEVELS: begin
				next_rdata[CW-1:0]                       = tx_count;
				next_rdata[ufci_pkg::LVL_RX_POS +: CW]   = rx_count;
			end
			default:                   next_rresp = ufci_pkg::RESP_SLVERR;
		endcase
	end

	// one read at a time, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= ufci_pkg::RESP_OKAY;
		end else if (do_read) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_FIELDS_GATED: assert property (wr_setup && !w_byte[0] |=> $stable(rx_trig_sel) && $stable(tx_trig_sel))
		else $error("setup fields changed without enable bit");
	AST_TX_FLUSH: assert property (wr_setup && w_byte[0] && w_byte[2] |=> ##1 tx_count == '0)
		else $error("tx fifo not emptied by reset bit");
	AST_RX_FLUSH: assert property (wr_setup && w_byte[0] && w_byte[1] |=> ##1 rx_count == '0)
		else $error("rx fifo not emptied by reset bit");
	AST_FEN_FOLLOWS: assert property (wr_setup |=> fifo_en == $past(w_byte[0]))
		else $error("fifo enable does not follow write");
	AST_RX_TRIG_28: assert property (rx_trig_sel == 2'h3 |-> rx_trig == CW'(28))
		else $error("rx trigger code 11 not 28");
	AST_TX_TRIG_30: assert property (tx_trig_sel == 2'h3 |-> tx_trig == CW'(30))
		else $error("tx trigger code 11 not 30");
	AST_LINE_FIRST: assert property (line_status_err |-> isr_code == 6'h06)
		else $error("line status not reported first");
	AST_TOP_BITS: assert property (do_read && araddr == 8'h04 |=> rdata[7:6] == {2{$past(fifo_en)}})
		else $error("identification top bits wrong");
	AST_IDLE_BIT: assert property (isr_code[0] == !(line_status_err || rx_data_int || rx_tmo_int
		|| thr_pend || modem_change || (enh_on && (xoff_flag || flow_flag))))
		else $error("pending bit wrong");
	AST_XOFF_HOLD: assert property (xoff_flag && !xon_detected |=> xoff_flag)
		else $error("xoff flag dropped before xon");
	AST_THR_CLEAR: assert property (isr_read && !(tx_was_busy && tx_count == '0) |=> !thr_pend)
		else $error("transmit empty not cleared by read");
	AST_TX_BLOCK_FULL: assert property (fifo_en && dma_mode && tx_count == cap |=> tx_dma_ready_n)
		else $error("tx ready not high when full");
	AST_RX_BLOCK_EMPTY: assert property (fifo_en && dma_mode && rx_count == '0 |=> rx_dma_ready_n)
		else $error("rx ready not high when empty");
	AST_TX_SINGLE: assert property (!(fifo_en && dma_mode) && tx_count == '0 |=> !tx_dma_ready_n)
		else $error("tx ready not low when empty");

	COV_RX_BLOCK: cover property (fifo_en && dma_mode ##1 $fell(rx_dma_ready_n));
	COV_THR_READ: cover property (thr_pend && isr_read);
	COV_XOFF_SHOWN: cover property (isr_code == 6'h10);
	COV_TX_FULL: cover property (fifo_en && tx_count == cap);
endmodule
`default_nettype wire

// [verification/ufci_partner.sv]
// far side model: transmit shifter and receive character source
`timescale 1ns/1ps
`default_nettype none
module ufci_partner (
	input  wire logic       aclk,
	input  wire logic       stall,
	input  wire logic       send,
	input  wire logic [7:0] send_char,
	input  wire logic [7:0] tx_char,
	input  wire logic       tx_char_valid,
	output logic            tx_shift_ready,
	output logic            rx_char_valid,
	output logic [7:0]      rx_char,
	output logic [7:0]      last
);
	// shifter takes a character whenever not stalled
	assign tx_shift_ready = ~stall;
	// one-cycle receive pulse, data scrambled between pulses
	always_ff @(posedge aclk) begin
		rx_char_valid <= send;
		rx_char <= send ? send_char : ~rx_char;
	end
	// capture each character handed over
	always_ff @(posedge aclk) begin
		if (tx_char_valid && tx_shift_ready) last <= tx_char;
	end
endmodule
`default_nettype wire

// [verification/uart_fifo_control_interrupt_status_test.sv]
// self-checking bench for the fifo control and identification block
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control_interrupt_status_test;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic stall = 1, send = 0, lse = 0, tmo = 0, mdm = 0, xo = 0, xn = 0, cts = 0;
	logic awready, wready, bvalid, arready, rvalid, tx_char_valid, tx_shift_ready;
	logic rx_char_valid, tx_dma_ready_n, rx_dma_ready_n, ptx, prx;
	logic [7:0] awaddr = 0, araddr = 0, send_char = 0, tx_char, rx_char, last, v;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] wdata = 0, rdata, rv, seed = 32'hAC63;
	logic [1:0] bresp, rresp, resp;
	int fails, n_compared, en, dma, enh, thre, xf, ff, rtr, ttr;
	int rxt[4] = '{8, 16, 24, 28};
	int txt[4] = '{16, 8, 24, 30};
	logic [7:0] rq[$], tq[$];

	// device and far side
	ufci_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .rx_char_valid, .rx_char, .tx_char, .tx_char_valid,
		.tx_shift_ready, .line_status_err(lse), .rx_timeout(tmo), .modem_change(mdm),
		.xoff_detected(xo), .xon_detected(xn), .cts_rts_change(cts), .tx_dma_ready_n,
		.rx_dma_ready_n);
	ufci_partner peer (.aclk, .stall, .send, .send_char, .tx_char, .tx_char_valid,
		.tx_shift_ready, .rx_char_valid, .rx_char, .last);

	// clock
	always #4 aclk = ~aclk;

	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// expected identification from model state
	function automatic logic [7:0] exp_id();
		logic [5:0] k;
		k = lse ? 6'h06 : (rq.size() >= (en ? rtr : 1)) ? 6'h04 :
			(tmo && rq.size() > 0) ? 6'h0C : thre ? 6'h02 : mdm ? 6'h00 :
			(enh && xf) ? 6'h10 : (enh && ff) ? 6'h20 : 6'h01;
		return {en ? 2'h3 : 2'h0, k};
	endfunction

	// transmit fifo fill: the oldest queued character sits in the shifter stage
	function automatic int fc();
		return (tq.size() > 0) ? tq.size() - 1 : 0;
	endfunction

	task chk(string n, logic [15:0] e, logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task wr(logic [7:0] a, logic [7:0] d);
		bit pa, pw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awready) begin
				awvalid <= 0;
				pa = 0;
			end
			if (pw && wready) begin
				wvalid <= 0;
				pw = 0;
			end
		end
		while (!bvalid) @(posedge aclk);
		resp = bresp;
		bready <= 0;
	endtask

	task rd(logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rv = rdata;
		resp = rresp;
		rready <= 0;
	endtask

	task st();
		repeat (4) @(posedge aclk);
	endtask

	// ready pin model
	task pins();
		if (en && dma) begin
			if (fc() == 32) ptx = 1;
			else if (fc() <= ttr) ptx = 0;
			if (rq.size() == 0) prx = 1;
			else if (rq.size() >= rtr || tmo) prx = 0;
		end else begin
			ptx = fc() != 0;
			prx = rq.size() == 0;
		end
		st();
		chk("tx ready", ptx, tx_dma_ready_n);
		chk("rx ready", prx, rx_dma_ready_n);
	endtask

	task idc();
		rd(8'h04);
		chk("ident", exp_id(), rv[7:0]);
		thre = 0;
		ff = 0;
	endtask

	task rxp();
		seed = xs(seed);
		@(posedge aclk);
		send_char <= seed[7:0];
		send <= 1;
		rq.push_back(seed[7:0]);
		@(posedge aclk);
		send <= 0;
	endtask

	task txw();
		seed = xs(seed);
		v = seed[15:8];
		wr(8'h0C, v);
		tq.push_back(v);
		thre = tq.size() == 1;
	endtask

	task drn();
		@(posedge aclk);
		stall <= 0;
		@(posedge aclk);
		stall <= 1;
		v = tq.pop_front();
		if (tq.size() == 1) thre = 1;
		pins();
		chk("tx char", v, last);
	endtask

	// status step: drive sources, pulse flags, read identification
	task sc(logic l, logic t, logic m, logic a, logic b, logic f);
		@(posedge aclk);
		lse <= l;
		tmo <= t;
		mdm <= m;
		xo <= a;
		xn <= b;
		cts <= f;
		@(posedge aclk);
		xo <= 0;
		xn <= 0;
		cts <= 0;
		if (a) xf = 1;
		else if (b) xf = 0;
		ff = ff | f;
		st();
		idc();
	endtask

	task final_report();
		if (fails == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// watchdog
	initial begin
		#(8 * 60000);
		fails++;
		final_report();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		idc();
		rd(8'h00);
		chk("setup", 16'h0, rv[7:0]);
		rd(8'h3C);
		chk("rresp", 16'h2, resp);
		wr(8'h40, 8'h00);
		chk("bresp", 16'h2, resp);
		wr(8'h00, 8'hF8);
		rd(8'h00);
		chk("setup", 16'h0, rv[7:0]);
		pins();
		wr(8'h08, 8'h10);
		enh = 1;
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, {2'(i), 6'h09});
			en = 1;
			dma = 1;
			rtr = rxt[i];
			rd(8'h00);
			chk("setup", {2'(i), 6'h09}, rv[7:0]);
			repeat (32) begin
				rxp();
				pins();
				idc();
			end
			repeat (32) begin
				rd(8'h10);
				chk("rx data", rq.pop_front(), rv[7:0]);
				pins();
			end
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, {2'h0, 2'(i), 4'h9});
			rtr = 8;
			ttr = txt[i];
			repeat (33) begin
				txw();
				pins();
			end
			repeat (33) drn();
		end
		txw();
		txw();
		idc();
		drn();
		idc();
		idc();
		drn();
		wr(8'h00, 8'h01);
		dma = 0;
		rtr = 8;
		rxp();
		sc(1, 1, 1, 1, 0, 0);
		sc(0, 1, 1, 0, 0, 0);
		sc(0, 0, 1, 0, 0, 0);
		sc(0, 0, 0, 0, 0, 0);
		sc(0, 0, 0, 0, 1, 0);
		sc(0, 0, 0, 0, 0, 1);
		idc();
		wr(8'h08, 8'h00);
		enh = 0;
		sc(0, 0, 0, 1, 0, 0);
		wr(8'h08, 8'h10);
		enh = 1;
		sc(0, 0, 0, 0, 1, 0);
		wstrb <= 4'h0;
		wr(8'h00, 8'hFF);
		wstrb <= 4'hF;
		rd(8'h00);
		chk("setup", 16'h01, rv[7:0]);
		rxp();
		repeat (3) txw();
		pins();
		wr(8'h00, 8'h05);
		tq = tq[0:0];
		thre = 1;
		rd(8'h00);
		chk("setup", 16'h01, rv[7:0]);
		rd(8'h14);
		chk("levels", 16'h0200, rv[15:0]);
		drn();
		wr(8'h00, 8'h03);
		rq.delete();
		rd(8'h14);
		chk("levels", 16'h0000, rv[15:0]);
		pins();
		final_report();
	end
endmodule
`default_nettype wire
